// file: pkg/nibble_cpu_defs.svh
// Constants for the nibble core: opcodes, reset values and warm-up counts.
`ifndef NIBBLE_CPU_DEFS_SVH
`define NIBBLE_CPU_DEFS_SVH
`define OP_ADC 5'h00
`define OP_ADD 5'h01
`define OP_SUB_BORROW 5'h02
`define OP_SUB 5'h03
`define OP_XOR 5'h04
`define OP_OR 5'h05
`define OP_AND 5'h06
`define OP_LDST 5'h07
`define OP_ADI 5'h08
`define OP_ADIM 5'h09
`define OP_SBI 5'h0a
`define OP_SBIM 5'h0b
`define OP_XORI 5'h0c
`define OP_ORI 5'h0d
`define OP_ANDI 5'h0e
`define OP_LOAD_IMM 5'h0f
`define OP_BR_NONZERO 5'h10
`define OP_BR_NOCARRY 5'h11
`define OP_BR_ZERO 5'h12
`define OP_BR_CARRY 5'h13
`define OP_CALL 5'h18
`define OP_DEC 5'h19
`define OP_RET 5'h1a
`define OP_SLEEP 5'h1b
`define OP_LJUMP_P0 5'h1c
`define OP_LJUMP_P1 5'h1d
`define OP_SHTJ 5'h1e
`define OP_NOP 5'h1f
`define DEC_ADD_SEL 4'h6
`define DEC_SUB_SEL 4'ha
`define PC_RESET 12'h000
`define IRQ_VEC_BASE 12'h001
`define STOP_WAKE_MASK 4'h9
`define WARM_RC_POR_CYC 15'h1000
`define WARM_RC_SHORT_CYC 15'h0100
`define WARM_XTAL_PAD_CYC 15'h0400
`define WARM_XTAL_LONG_CYC 16384
`endif

// file: pkg/nibble_cpu_pkg.sv
// Types shared by the nibble core and its bench.
`include "nibble_cpu_defs.svh"
package nibble_cpu_pkg;
	typedef enum logic [1:0] {
		ST_WARM = 2'b00,
		ST_RUN = 2'b01,
		ST_HALT = 2'b11,
		ST_STOP = 2'b10
	} cpu_state_type;
	typedef enum logic [1:0] {WK_POR = 2'b00, WK_PAD = 2'b01, WK_STOP = 2'b10} warm_kind_type;
	typedef struct packed {
		logic en;
		logic [9:0] addr;
		logic [3:0] data;
	} mem_wr_type;
	typedef struct packed {
		cpu_state_type st;
		warm_kind_type wk;
		logic [14:0] warm_cnt;
		logic [11:0] pc;
		logic [3:0] ac;
		logic carry_flag;
		logic [3:0] table_branch_reg;
		logic [3:0][12:0] stack;
		logic [1:0] sp;
		logic in_isr;
		logic [3:0] pend;
		logic [3:0] ack;
		mem_wr_type wr;
		logic [3:0] irq_m;
		logic [3:0] irq_s;
		logic pad_m;
		logic pad_s;
		logic rc_m;
		logic rc_s;
	} core_state_type;
endpackage

// file: rtl/nibble_cpu_instruction_exec.sv
// Single-cycle decode and execute core of the 4-bit micro-controller.
`include "nibble_cpu_defs.svh"
// Overview of operation
// - Every instruction is one 16-bit word executed in one cycle.
// - Add memory, working register and carry; optional write-back to memory.
// - Add memory and working register without carry-in; optional write-back.
// - Memory plus inverted working register plus carry; optional write-back.
// - Memory plus inverted working register plus one; optional write-back.
// - XOR, OR, AND with working register leave carry unchanged.
// - Shift right inserts zero on top, old bit 0 goes to carry.
// - Immediate add or subtract with memory; odd opcodes also write memory.
// - Immediate XOR, OR, AND write register and memory, carry kept.
// - Decimal adjust after add or subtract writes register, memory, carry.
// - Load, store, and load-immediate into both register and memory.
// - Branch on register zero, nonzero, carry set, carry clear.
// - Branch when the selected working register bit is one.
// - Call pushes carry and next address, keeps the page bit.
// - Value return loads table register and working register; irq return restores carry.
// - Long jump loads target together with the page bit.
// - Table jump forms counter from upper bits, table register, working register.
// - All-ones word only advances the program counter.
// - Light sleep halts the core; any interrupt wakes it.
// - Deep sleep stops the chip; only port or external interrupt wakes.
// - After wake the service routine runs, then the instruction after sleep.
// - Warm-up counts before execution depend on oscillator mode and cause.
module nibble_cpu_instruction_exec #(
	parameter int unsigned WARM_XTAL_LONG = `WARM_XTAL_LONG_CYC
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Pins from outside the clock domain.
	input wire logic pad_rst_n_i,
	input wire logic osc_rc_mode_i,
	input wire logic [3:0] irq_req_i,
	// Program ROM.
	output logic [11:0] rom_addr_o,
	input wire logic [15:0] rom_data_i,
	// Data RAM.
	output logic [9:0] mem_raddr_o,
	input wire logic [3:0] mem_rdata_i,
	output nibble_cpu_pkg::mem_wr_type mem_wr_o,
	// Status.
	output logic [3:0] irq_ack_o,
	output logic [3:0] working_nibble_o,
	output logic carry_flag_o,
	output logic [3:0] table_branch_o,
	output logic cpu_halted_o,
	output logic chip_stop_o,
	output logic warm_busy_o
);
	import nibble_cpu_pkg::*;

	core_state_type s_reg;
	core_state_type s_next;
	logic [15:0] instr;
	logic [4:0] op;
	logic [3:0] imm;
	logic [9:0] raddr;
	logic [3:0] mem_operand;
	logic [3:0] addb;
	logic cin;
	logic [4:0] sum;
	logic [3:0] lres;
	logic [3:0] lsrc;
	logic [3:0] pend_all;
	logic [1:0] vec_idx;
	logic take;
	logic exec;
	logic [14:0] warm_lim;
	logic [12:0] top;
	logic [11:0] pc_inc;
	logic [11:0] near_tgt;
	logic wflag;
	logic [3:0] wdat;

	// Instruction fields; the whole word arrives in one fetch.
	assign instr = rom_data_i;
	assign op = instr[15:11];
	assign imm = instr[10:7];
	assign pc_inc = s_reg.pc + 12'h001;
	assign near_tgt = {s_reg.pc[11], instr[10:0]};
	assign top = s_reg.stack[s_reg.sp - 2'd1];

	// Bank bits apply only to the accumulator type group.
	assign raddr = (op[4:3] == 2'b00) ? {instr[9:7], instr[6:0]} : {3'h0, instr[6:0]};
	// A write still in flight is forwarded to the reader.
	assign mem_operand = (s_reg.wr.en && s_reg.wr.addr == raddr) ? s_reg.wr.data : mem_rdata_i;

	// Adder operand selection for all add and subtract forms.
	always_comb begin
		addb = s_reg.ac;
		cin = 1'b0;
		case (op)
			`OP_ADC: cin = s_reg.carry_flag;
			`OP_ADD: cin = 1'b0;
			`OP_SUB_BORROW: begin
				addb = ~s_reg.ac;
				cin = s_reg.carry_flag;
			end
			`OP_SUB: begin
				addb = ~s_reg.ac;
				cin = 1'b1;
			end
			`OP_ADI, `OP_ADIM: addb = imm;
			`OP_SBI, `OP_SBIM: begin
				addb = ~imm;
				cin = 1'b1;
			end
			default: cin = 1'b0;
		endcase
	end

	// Carry is the fifth bit of a 4-bit add.
	assign sum = {1'b0, mem_operand} + {1'b0, addb} + {4'h0, cin};

	// Logic unit shared by register and immediate forms.
	assign lsrc = op[3] ? imm : s_reg.ac;
	always_comb begin
		case (op[1:0])
			2'b00: lres = mem_operand ^ lsrc;
			2'b01: lres = mem_operand | lsrc;
			default: lres = mem_operand & lsrc;
		endcase
	end

	// Pending requests and fixed priority, lowest index first.
	assign pend_all = s_reg.pend | s_reg.irq_s;
	always_comb begin
		vec_idx = 2'd3;
		for (int i = 3; i >= 0; i--) begin
			if (pend_all[i]) begin
				vec_idx = 2'(i);
			end
		end
	end
	assign take = (s_reg.st == ST_RUN || s_reg.st == ST_HALT) && !s_reg.in_isr && |pend_all;
	assign exec = (s_reg.st == ST_RUN) && !take;

	// Warm-up length by oscillator mode and by what started it.
	always_comb begin
		if (s_reg.rc_s) begin
			warm_lim = (s_reg.wk == WK_POR) ? `WARM_RC_POR_CYC : `WARM_RC_SHORT_CYC;
		end else begin
			warm_lim = (s_reg.wk == WK_PAD) ? `WARM_XTAL_PAD_CYC : 15'(WARM_XTAL_LONG);
		end
	end

	// Next-state logic for the whole core.
	always_comb begin
		s_next = s_reg;
		wflag = 1'b0;
		wdat = lres;
		s_next.irq_m = irq_req_i;
		s_next.irq_s = s_reg.irq_m;
		s_next.pad_m = pad_rst_n_i;
		s_next.pad_s = s_reg.pad_m;
		s_next.rc_m = osc_rc_mode_i;
		s_next.rc_s = s_reg.rc_m;
		s_next.ack = 4'h0;
		s_next.wr.en = 1'b0;
		s_next.pend = pend_all;
		case (s_reg.st)
			ST_WARM: begin
				if (s_reg.warm_cnt >= warm_lim - 15'h0001) begin
					s_next.st = ST_RUN;
					s_next.warm_cnt = 15'h0000;
				end else begin
					s_next.warm_cnt = s_reg.warm_cnt + 15'h0001;
				end
			end
			ST_STOP: begin
				if (|(pend_all & `STOP_WAKE_MASK)) begin
					s_next.st = ST_WARM;
					s_next.wk = WK_STOP;
					s_next.warm_cnt = 15'h0000;
				end
			end
			default: begin
				if (take) begin
					// Counter already points past a sleep, so return resumes after it.
					s_next.stack[s_reg.sp] = {s_reg.carry_flag, s_reg.pc};
					s_next.sp = s_reg.sp + 2'd1;
					s_next.pc = `IRQ_VEC_BASE + {10'h000, vec_idx};
					s_next.in_isr = 1'b1;
					s_next.st = ST_RUN;
					s_next.ack = 4'h1 << vec_idx;
					s_next.pend = pend_all & ~(4'h1 << vec_idx);
				end else if (exec) begin
					s_next.pc = pc_inc;
					case (op)
						`OP_ADC, `OP_ADD, `OP_SUB_BORROW, `OP_SUB: begin
							s_next.ac = sum[3:0];
							s_next.carry_flag = sum[4];
							wflag = instr[10];
							wdat = sum[3:0];
						end
						`OP_XOR, `OP_OR, `OP_AND: begin
							s_next.ac = lres;
							wflag = instr[10];
						end
						`OP_LDST: begin
							if (instr[10]) begin
								wflag = 1'b1;
								wdat = s_reg.ac;
							end else begin
								s_next.ac = mem_operand;
							end
						end
						`OP_ADI, `OP_ADIM, `OP_SBI, `OP_SBIM: begin
							s_next.ac = sum[3:0];
							s_next.carry_flag = sum[4];
							wflag = op[0];
							wdat = sum[3:0];
						end
						`OP_XORI, `OP_ORI, `OP_ANDI: begin
							s_next.ac = lres;
							wflag = 1'b1;
						end
						`OP_LOAD_IMM: begin
							s_next.ac = imm;
							wflag = 1'b1;
							wdat = imm;
						end
						`OP_BR_NONZERO: if (s_reg.ac != 4'h0) s_next.pc = near_tgt;
						`OP_BR_NOCARRY: if (!s_reg.carry_flag) s_next.pc = near_tgt;
						`OP_BR_ZERO: if (s_reg.ac == 4'h0) s_next.pc = near_tgt;
						`OP_BR_CARRY: if (s_reg.carry_flag) s_next.pc = near_tgt;
						5'h14, 5'h15, 5'h16, 5'h17: begin
							if (s_reg.ac[op[1:0]]) s_next.pc = near_tgt;
						end
						`OP_CALL: begin
							s_next.stack[s_reg.sp] = {s_reg.carry_flag, pc_inc};
							s_next.sp = s_reg.sp + 2'd1;
							s_next.pc = near_tgt;
						end
						`OP_DEC: begin
							wflag = (imm == `DEC_ADD_SEL) || (imm == `DEC_SUB_SEL);
							if (imm == `DEC_ADD_SEL) begin
								if (s_reg.ac > 4'h9 || s_reg.carry_flag) begin
									wdat = s_reg.ac + 4'h6;
									s_next.carry_flag = 1'b1;
								end else begin
									wdat = s_reg.ac;
									s_next.carry_flag = 1'b0;
								end
							end else begin
								if (s_reg.ac > 4'h9 || !s_reg.carry_flag) begin
									wdat = s_reg.ac + 4'ha;
									s_next.carry_flag = 1'b0;
								end else begin
									wdat = s_reg.ac;
									s_next.carry_flag = 1'b1;
								end
							end
							if (wflag) s_next.ac = wdat;
							if (!wflag) s_next.carry_flag = s_reg.carry_flag;
						end
						`OP_RET: begin
							s_next.sp = s_reg.sp - 2'd1;
							s_next.pc = top[11:0];
							if (instr[10]) begin
								s_next.carry_flag = top[12];
								s_next.in_isr = 1'b0;
							end else begin
								s_next.table_branch_reg = instr[7:4];
								s_next.ac = instr[3:0];
							end
						end
						`OP_SLEEP: s_next.st = instr[10] ? ST_STOP : ST_HALT;
						`OP_LJUMP_P0, `OP_LJUMP_P1: s_next.pc = {op[0], instr[10:0]};
						`OP_SHTJ: begin
							if (instr[10]) begin
								s_next.pc = {s_reg.pc[11:8], s_reg.table_branch_reg, s_reg.ac};
							end else begin
								s_next.ac = {1'b0, s_reg.ac[3:1]};
								s_next.carry_flag = s_reg.ac[0];
							end
						end
						default: s_next.pc = pc_inc;
					endcase
				end
			end
		endcase
		// Write-back is issued one cycle later from flip-flops.
		s_next.wr.en = wflag;
		s_next.wr.addr = raddr;
		s_next.wr.data = wdat;
		// Pad reset held low restarts with the short warm-up.
		if (!s_reg.pad_s) begin
			s_next.st = ST_WARM;
			s_next.wk = WK_PAD;
			s_next.warm_cnt = 15'h0000;
			s_next.pc = `PC_RESET;
			s_next.sp = 2'd0;
			s_next.in_isr = 1'b0;
			s_next.pend = 4'h0;
			s_next.ack = 4'h0;
			s_next.wr.en = 1'b0;
		end
	end

	// State register; power-on starts the long warm-up.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_reg <= '0;
			s_reg.pad_m <= 1'b1;
			s_reg.pad_s <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs from the state register, except the data read address taken from the instruction word.
	assign rom_addr_o = s_reg.pc;
	assign mem_raddr_o = raddr;
	assign mem_wr_o = s_reg.wr;
	assign irq_ack_o = s_reg.ack;
	assign working_nibble_o = s_reg.ac;
	assign carry_flag_o = s_reg.carry_flag;
	assign table_branch_o = s_reg.table_branch_reg;
	assign cpu_halted_o = (s_reg.st == ST_HALT);
	assign chip_stop_o = (s_reg.st == ST_STOP);
	assign warm_busy_o = (s_reg.st == ST_WARM);

	// Checks on the execute path and on sleep and wake.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i || !s_reg.pad_s);

	a_nop_pc_step: assert property (exec && op == `OP_NOP |=> s_reg.pc == $past(pc_inc)
		&& s_reg.ac == $past(s_reg.ac)) else $error("nop did not just step the counter");
	a_add_carry_out: assert property (exec && op == `OP_ADD |=> {s_reg.carry_flag, s_reg.ac} ==
		{1'b0, $past(mem_operand)} + {1'b0, $past(s_reg.ac)}) else $error("add result wrong");
	a_logic_keeps_carry: assert property (exec && (op == `OP_XOR || op == `OP_ANDI)
		|=> s_reg.carry_flag == $past(s_reg.carry_flag)) else $error("logic op changed carry");
	a_shift_right: assert property (exec && op == `OP_SHTJ && !instr[10] |=> s_reg.carry_flag ==
		$past(s_reg.ac[0]) && !s_reg.ac[3]) else $error("shift right wrong");
	a_long_jump_page: assert property (exec && op == `OP_LJUMP_P1 |=> s_reg.pc ==
		{1'b1, $past(instr[10:0])}) else $error("long jump lost page bit");
	a_table_jump: assert property (exec && op == `OP_SHTJ && instr[10] |=> s_reg.pc[7:0] ==
		{$past(s_reg.table_branch_reg), $past(s_reg.ac)}) else $error("table jump target wrong");
	a_call_push: assert property (exec && op == `OP_CALL |=> s_reg.sp == $past(s_reg.sp) + 2'd1
		&& s_reg.pc[11] == $past(s_reg.pc[11])) else $error("call push wrong");
	a_store_write: assert property (exec && op == `OP_LDST && instr[10] |=> mem_wr_o.en
		&& mem_wr_o.data == $past(s_reg.ac)) else $error("store did not write");
	a_halt_holds_pc: assert property (s_reg.st == ST_HALT && !take |=> s_reg.pc ==
		$past(s_reg.pc)) else $error("counter moved in light sleep");
	a_stop_wake_warm: assert property (s_reg.st == ST_STOP && |(pend_all & `STOP_WAKE_MASK)
		|=> warm_busy_o ##0 s_reg.wk == WK_STOP) else $error("deep sleep wake wrong");
	a_wake_vector: assert property (s_reg.st == ST_HALT && take |=> s_reg.in_isr && s_reg.pc ==
		`IRQ_VEC_BASE + {10'h000, $past(vec_idx)}) else $error("wake did not vector");

	c_halt_wake: cover property (s_reg.st == ST_HALT ##1 s_reg.in_isr);
	c_stop_wake: cover property (s_reg.st == ST_STOP ##1 s_reg.st == ST_WARM);
	c_call_ret: cover property (exec && op == `OP_CALL ##[1:20] exec && op == `OP_RET);
endmodule

// file: sim/nibble_mem_model.sv
// Program ROM and banked data RAM model on the far side of the nibble core.
module nibble_mem_model
	import nibble_cpu_pkg::*;
(
	// Clock.
	input wire logic clk_i,
	// Program side.
	input wire logic [11:0] rom_addr_i,
	output logic [15:0] rom_data_o,
	// Data side.
	input wire logic [9:0] mem_raddr_i,
	output logic [3:0] mem_rdata_o,
	input wire nibble_cpu_pkg::mem_wr_type mem_wr_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] rom [4096];
	logic [3:0] ram [1024];
	// Both memories answer within the same cycle, as the core expects.
	assign rom_data_o = rom[rom_addr_i];
	assign mem_rdata_o = ram[mem_raddr_i];
	// The RAM takes a write on the edge where the strobe is high.
	always @(posedge clk_i) begin
		if (mem_wr_i.en) begin
			ram[mem_wr_i.addr] <= mem_wr_i.data;
		end
	end
endmodule

// file: sim/nibble_cpu_instruction_exec_test.sv
// Self-checking bench for the nibble core decode and execute block.
module nibble_cpu_instruction_exec_test;
	timeunit 1ns;
	timeprecision 1ps;
	import nibble_cpu_pkg::*;
	localparam int WL = 32;
	logic clk_i, sys_rst_i, pad_rst_n_i, osc_rc_mode_i, carry_flag_o;
	logic cpu_halted_o, chip_stop_o, warm_busy_o;
	logic [3:0] irq_req_i, mem_rdata_i, irq_ack_o, working_nibble_o, table_branch_o;
	logic [11:0] rom_addr_o;
	logic [15:0] rom_data_i;
	logic [9:0] mem_raddr_o;
	mem_wr_type mem_wr_o;
	int failures, checks_done;

	nibble_cpu_instruction_exec #(.WARM_XTAL_LONG(WL)) dut (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .pad_rst_n_i(pad_rst_n_i), .osc_rc_mode_i(osc_rc_mode_i),
		.irq_req_i(irq_req_i), .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i),
		.mem_raddr_o(mem_raddr_o), .mem_rdata_i(mem_rdata_i), .mem_wr_o(mem_wr_o),
		.irq_ack_o(irq_ack_o), .working_nibble_o(working_nibble_o),
		.carry_flag_o(carry_flag_o), .table_branch_o(table_branch_o),
		.cpu_halted_o(cpu_halted_o), .chip_stop_o(chip_stop_o), .warm_busy_o(warm_busy_o));
	nibble_mem_model mem (.clk_i(clk_i), .rom_addr_i(rom_addr_o), .rom_data_o(rom_data_i),
		.mem_raddr_i(mem_raddr_o), .mem_rdata_o(mem_rdata_i), .mem_wr_i(mem_wr_o));

	// Free-running 40 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// Compares one result and counts it.
	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	// Builds an instruction word from opcode, middle field and operand address.
	function automatic logic [15:0] w(input logic [4:0] op, input logic [3:0] f,
		input logic [6:0] x);
		return {op, f, x};
	endfunction

	// Counts cycles until warm-up ends, bounded so a stuck core cannot hang here.
	task automatic wait_warm(output int n);
		n = 0;
		while (warm_busy_o !== 1'b0 && n < 2000) begin
			@(negedge clk_i);
			n++;
		end
		chk("warm_done", 0, warm_busy_o);
	endtask

	// Loads a program over a ROM of self-jumps, resets, and lets it run out.
	task automatic run(input logic [15:0] p[$]);
		int n;
		foreach (mem.rom[i]) mem.rom[i] = {4'he, 12'(i)};
		foreach (p[i]) mem.rom[i] = p[i];
		sys_rst_i = 1'b1;
		repeat (4) @(negedge clk_i);
		sys_rst_i = 1'b0;
		wait_warm(n);
		repeat (p.size() + 4) @(negedge clk_i);
	endtask

	// Raises an interrupt request for one cycle.
	task automatic irq_pulse(input logic [3:0] v);
		irq_req_i = v;
		@(negedge clk_i);
		irq_req_i = 4'h0;
	endtask

	// Carry add, plain add with write-back, load and store.
	task automatic t_add();
		mem.ram[5] = 4'h9;
		mem.ram[6] = 4'h3;
		run('{w(7, 0, 5), w(1, 8, 5), w(0, 0, 6), w(7, 8, 7)});
		chk("ac", 4'h6, working_nibble_o);
		chk("carry", 0, carry_flag_o);
		chk("m5", 4'h2, mem.ram[5]);
		chk("m7", 4'h6, mem.ram[7]);
	endtask

	// Subtract forms and immediate add or subtract.
	task automatic t_sub();
		mem.ram[6] = 4'h3;
		run('{w(15, 5, 8), w(3, 0, 6), w(2, 8, 6), w(11, 1, 6), w(8, 15, 6)});
		chk("ac", 4'h2, working_nibble_o);
		chk("carry", 1, carry_flag_o);
		chk("m6", 4'h3, mem.ram[6]);
		chk("m8", 4'h5, mem.ram[8]);
	endtask

	// Shift sets carry, then logic operations must keep it.
	task automatic t_logic();
		run('{w(15, 7, 9), 16'hf000, w(14, 14, 9), w(12, 15, 9), w(6, 8, 9)});
		chk("ac", 4'h9, working_nibble_o);
		chk("carry", 1, carry_flag_o);
		chk("m9", 4'h9, mem.ram[9]);
	endtask

	// Decimal adjust after an add with carry and after a borrowing subtract.
	task automatic t_dec();
		run('{w(15, 8, 5), w(1, 0, 5), w(25, 6, 5), w(15, 1, 10), w(7, 0, 5), w(3, 0, 10),
			w(25, 10, 11)});
		chk("m5", 4'h6, mem.ram[5]);
		chk("m11", 4'h5, mem.ram[11]);
		chk("ac", 4'h5, working_nibble_o);
		chk("carry", 0, carry_flag_o);
	endtask

	// Each branch taken or not taken; a wrong path marks memory.
	task automatic t_branch();
		run('{w(15, 0, 20), {5'h12, 11'd3}, w(15, 15, 20), {5'h10, 11'd2}, {5'h11, 11'd6},
			w(15, 15, 20), {5'h13, 11'd5}, w(15, 4, 21), {5'h16, 11'd10}, w(15, 15, 20),
			{5'h14, 11'd9}, 16'hffff, 16'he800});
		chk("m20", 4'h0, mem.ram[20]);
		chk("ac", 4'h4, working_nibble_o);
		chk("pc", 12'h800, rom_addr_o);
	endtask

	// Call, value return, then table jump built from the returned values.
	task automatic t_call();
		run('{w(15, 7, 5), {5'h18, 11'd4}, 16'hf7ff, w(15, 15, 20), 16'hd036});
		chk("table_branch", 4'h3, table_branch_o);
		chk("ac", 4'h6, working_nibble_o);
		chk("pc", 12'h036, rom_addr_o);
	endtask

	// Light or deep sleep, wake by interrupt, service, then resume after sleep.
	task automatic t_sleep(input logic stop);
		int n;
		mem.ram[30] = 4'h0;
		mem.ram[31] = 4'h0;
		run('{{5'h1c, 11'd5}, w(15, 11, 30), 16'hd400, 16'hffff, 16'hffff,
			stop ? 16'hdc00 : 16'hd800, w(15, 5, 31)});
		chk("asleep", 1, stop ? chip_stop_o : cpu_halted_o);
		if (stop) begin
			irq_pulse(4'h2);
			repeat (10) @(negedge clk_i);
			chk("stopped", 1, chip_stop_o);
		end
		irq_pulse(stop ? 4'h1 : 4'h2);
		n = 0;
		while (irq_ack_o === 4'h0 && n < 200) begin
			@(negedge clk_i);
			n++;
		end
		chk("ack", stop ? 4'h1 : 4'h2, irq_ack_o);
		repeat (60) @(negedge clk_i);
		chk("m30", stop ? 4'hb : 4'h0, mem.ram[30]);
		chk("m31", 4'h5, mem.ram[31]);
		chk("pc", 12'h007, rom_addr_o);
	endtask

	// Pad reset followed by a warm-up of the given length.
	task automatic pad_warm(input int lo);
		int n;
		pad_rst_n_i = 1'b0;
		repeat (4) @(negedge clk_i);
		pad_rst_n_i = 1'b1;
		wait_warm(n);
		chk("pad_warm", 1, n >= lo && n <= lo + 6);
	endtask

	// Warm-up lengths after power-on with osc_rc_mode_i low and after pad reset in both oscillator modes.
	task automatic t_warm();
		int n;
		sys_rst_i = 1'b1;
		repeat (4) @(negedge clk_i);
		sys_rst_i = 1'b0;
		wait_warm(n);
		chk("por_warm", 1, n >= WL && n <= WL + 4);
		pad_warm(1024);
		osc_rc_mode_i = 1'b1;
		repeat (4) @(negedge clk_i);
		pad_warm(256);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Cuts a hang short well beyond the expected run length.
	initial begin
		#(25 * 30000);
		failures++;
		end_sim();
	end

	// Main sequence.
	initial begin
		sys_rst_i = 1'b1;
		pad_rst_n_i = 1'b1;
		osc_rc_mode_i = 1'b0;
		irq_req_i = 4'h0;
		failures = 0;
		checks_done = 0;
		t_add();
		t_sub();
		t_logic();
		t_dec();
		t_branch();
		t_call();
		t_sleep(1'b0);
		t_sleep(1'b1);
		t_warm();
		end_sim();
	end
endmodule
